// ### include/adc_seq_pkg.sv
// Constants and types shared by the converter sequencing control
package adc_seq_pkg;
    localparam int          CHANNELS         = 8;
    localparam int          CHAN_W           = 3;
    localparam int          RESULT_W         = 8;
    // Conversion time, figure as printed at the 16 MHz reference clock
    localparam int          CONV_TIME_NS     = 7500;
    localparam int          CLOCK_PERIOD_NS  = 10;
    // Whole conversion in clock cycles, rounded down as a longest time
    localparam int          CONV_CYCLES      = CONV_TIME_NS / CLOCK_PERIOD_NS;
    // Cycles per bit decision; the remainder goes to sampling
    localparam int          STEP_CYCLES      = CONV_CYCLES / (RESULT_W + 1);
    localparam int          STEP_W           = 8;
    // Mode register fields
    localparam int          MODE_CHAN_LSB    = 0;
    localparam int          MODE_SCAN_BIT    = 3;
    localparam int          MODE_HWSTART_BIT = 4;
    localparam int          MODE_RUN_BIT     = 7;
    localparam logic [7:0]  MODE_RESET       = 8'h00;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_DECIDE
    } seq_state_t;
endpackage

// ### include/sar_if.sv
// Handshake between the sequencer and the bit-decision engine
`timescale 1ns/1ps
interface sar_if #(parameter int WIDTH = 8);
    logic             start;
    logic             compare_hi;
    logic [WIDTH-1:0] trial;
    logic [WIDTH-1:0] value;
    logic             done;
    modport seq (output start, output compare_hi, input trial, input value, input done);
    modport sar (input start, input compare_hi, output trial, output value, output done);
endinterface

// ### rtl/sar_engine.sv
// Successive-approximation bit engine, MSB first
`timescale 1ns/1ps
module sar_engine #(
    parameter int WIDTH      = 8,
    parameter int STEP_CYCLES = 93
) (
    input  wire logic clock,
    input  wire logic rst,
    sar_if.sar        bus
);
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] bit_q;
    logic [7:0]       step_q;
    logic             busy_q;
    logic             done_q;

    assign bus.trial = value_q | bit_q;
    assign bus.value = value_q;
    assign bus.done  = done_q;

    always_ff @(posedge clock) begin
        if (rst || bus.start) begin
            value_q <= '0;
            bit_q   <= {1'b1, {(WIDTH-1){1'b0}}};
            step_q  <= '0;
            busy_q  <= bus.start && !rst;
            done_q  <= 1'b0;
        end else if (busy_q) begin
            done_q <= 1'b0;
            if (step_q == 8'(STEP_CYCLES - 1)) begin
                step_q <= '0;
                // Keep trial bit when comparator says input is above it
                if (bus.compare_hi) begin
                    value_q <= value_q | bit_q;
                end
                bit_q <= bit_q >> 1;
                if (bit_q[0]) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end else begin
                step_q <= step_q + 8'h01;
            end
        end else begin
            done_q <= 1'b0;
        end
    end
endmodule // sar_engine

// ### rtl/adc_sequencing_control.sv
// Converter sequencing control: start sources, scan/select, result and request
`timescale 1ns/1ps
module adc_sequencing_control #(
    parameter int CHANNELS = adc_seq_pkg::CHANNELS,
    parameter int WIDTH    = adc_seq_pkg::RESULT_W
) (
    input  wire logic                            clock,
    input  wire logic                            rst,
    input  wire logic [7:0]                      mode_wdata,
    input  wire logic                            mode_write,
    input  wire logic                            external_trigger_input,
    input  wire logic                            compare_hi,
    output logic      [7:0]                      converter_mode_register,
    output logic      [WIDTH-1:0]                conversion_result_register,
    output logic      [adc_seq_pkg::CHAN_W-1:0]  analog_input_channels,
    output logic      [WIDTH-1:0]                dac_trial,
    output logic                                 sample_hold,
    output logic                                 busy,
    output logic                                 conversion_done_request
);
    sar_if #(.WIDTH(WIDTH)) sar ();

    adc_seq_pkg::seq_state_t         state_q;
    logic [adc_seq_pkg::CHAN_W-1:0]  chan_q;
    logic [adc_seq_pkg::STEP_W-1:0]  samp_q;
    logic                            trig_q;
    logic                            start_pulse_q;

    logic run_bit;
    logic scan_bit;
    logic hw_bit;
    logic [adc_seq_pkg::CHAN_W-1:0] sel_chan;
    logic trig_edge;
    logic sw_start;
    logic start_now;
    logic stop_req;
    logic arm_req;
    logic redirect;
    logic samp_end;
    logic conv_end;

    // Last sampling count: the budget left over after the bit steps
    localparam logic [adc_seq_pkg::STEP_W-1:0] SAMP_LAST = adc_seq_pkg::STEP_W'(
        adc_seq_pkg::CONV_CYCLES - WIDTH * adc_seq_pkg::STEP_CYCLES - 1);

    // Channel a run opens on; a scan group always starts at channel 0
    function automatic logic [adc_seq_pkg::CHAN_W-1:0] first_chan(input logic [7:0] mode);
        first_chan = mode[adc_seq_pkg::MODE_SCAN_BIT] ? '0
                   : mode[adc_seq_pkg::MODE_CHAN_LSB +: adc_seq_pkg::CHAN_W];
    endfunction

    assign run_bit  = converter_mode_register[adc_seq_pkg::MODE_RUN_BIT];
    assign scan_bit = converter_mode_register[adc_seq_pkg::MODE_SCAN_BIT];
    assign hw_bit   = converter_mode_register[adc_seq_pkg::MODE_HWSTART_BIT];
    assign sel_chan = converter_mode_register[adc_seq_pkg::MODE_CHAN_LSB +: adc_seq_pkg::CHAN_W];
    assign trig_edge = external_trigger_input && !trig_q;
    // Software start: write with run set and hardware source off
    assign sw_start = mode_write && mode_wdata[adc_seq_pkg::MODE_RUN_BIT]
                      && !mode_wdata[adc_seq_pkg::MODE_HWSTART_BIT];
    assign start_now = sw_start || (run_bit && hw_bit && trig_edge);
    assign stop_req  = mode_write && !mode_wdata[adc_seq_pkg::MODE_RUN_BIT];
    // A write that picks the hardware source waits idle for a fresh edge
    assign arm_req   = mode_write && mode_wdata[adc_seq_pkg::MODE_HWSTART_BIT];
    assign redirect  = stop_req || start_now || arm_req;
    assign samp_end  = (state_q == adc_seq_pkg::ST_SAMPLE) && (samp_q == SAMP_LAST);
    assign conv_end  = (state_q == adc_seq_pkg::ST_DECIDE) && sar.done;

    assign sar.start      = start_pulse_q;
    assign sar.compare_hi = compare_hi;

    sar_engine #(
        .WIDTH      (WIDTH),
        .STEP_CYCLES(adc_seq_pkg::STEP_CYCLES)
    ) u_sar (
        .clock(clock),
        .rst  (rst),
        .bus  (sar.sar)
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            converter_mode_register <= adc_seq_pkg::MODE_RESET;
        end else if (mode_write) begin
            converter_mode_register <= mode_wdata;
        end
    end

    // Resets low like the idle pin, so no false edge follows reset
    always_ff @(posedge clock) begin
        if (rst) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= external_trigger_input;
        end
    end

    // Sequencer state; a stop write wins, otherwise a start restarts from sampling
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= adc_seq_pkg::ST_IDLE;
        end else if (stop_req) begin
            state_q <= adc_seq_pkg::ST_IDLE;
        end else if (start_now) begin
            state_q <= adc_seq_pkg::ST_SAMPLE;
        end else if (arm_req) begin
            state_q <= adc_seq_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (samp_end) begin
                        state_q <= adc_seq_pkg::ST_DECIDE;
                    end
                end
                adc_seq_pkg::ST_DECIDE: begin
                    // No gap: select repeats, scan moves on to the next channel
                    if (conv_end) begin
                        state_q <= adc_seq_pkg::ST_SAMPLE;
                    end
                end
                // Fourth code of the two-bit state is unused; recover to idle
                default: begin
                    state_q <= adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Remaining budget spent sampling so the total stays fixed
    always_ff @(posedge clock) begin
        if (rst || start_now || conv_end) begin
            samp_q <= '0;
        end else if (state_q == adc_seq_pkg::ST_SAMPLE && !samp_end) begin
            samp_q <= samp_q + 1'b1;
        end
    end

    // Engine kick at the end of sampling, unless the run was redirected
    always_ff @(posedge clock) begin
        if (rst) begin
            start_pulse_q <= 1'b0;
        end else begin
            start_pulse_q <= samp_end && !redirect;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chan_q <= '0;
        end else if (start_now && !stop_req) begin
            chan_q <= mode_write ? first_chan(mode_wdata)
                                 : first_chan(converter_mode_register);
        end else if (conv_end && !redirect) begin
            if (scan_bit) begin
                // Scan group runs 0..selected channel, then wraps
                chan_q <= (chan_q >= sel_chan) ? '0 : chan_q + 1'b1;
            end else begin
                chan_q <= sel_chan;
            end
        end
    end

    // Result is held until the next transfer; software only reads it
    always_ff @(posedge clock) begin
        if (rst) begin
            conversion_result_register <= '0;
        end else if (conv_end) begin
            conversion_result_register <= sar.value;
        end
    end

    // One-cycle request per transfer, meant for a memory-transfer service
    always_ff @(posedge clock) begin
        if (rst) begin
            conversion_done_request <= 1'b0;
        end else begin
            conversion_done_request <= conv_end;
        end
    end

    // Channel select and trial value reach the pins one cycle late
    always_ff @(posedge clock) begin
        if (rst) begin
            analog_input_channels <= '0;
            dac_trial             <= '0;
        end else begin
            analog_input_channels <= chan_q;
            dac_trial             <= sar.trial;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sample_hold <= 1'b0;
        end else begin
            sample_hold <= (state_q == adc_seq_pkg::ST_SAMPLE);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_q != adc_seq_pkg::ST_IDLE);
        end
    end
endmodule // adc_sequencing_control

// ### testbench/analog_front_end.sv
// Behavioural analog front end: one fixed level per channel and a comparator
`timescale 1ns/1ps
module analog_front_end #(
    parameter logic [63:0] LEVELS = 64'h0
) (
    input  wire logic [2:0] channel,
    input  wire logic [7:0] trial,
    output logic            compare_hi
);
    // Only the selected channel reaches the comparator
    assign compare_hi = LEVELS[channel*8 +: 8] >= trial;
endmodule // analog_front_end

// ### testbench/adc_sequencing_control_props.sv
// Port assertions for the converter sequencing control
`timescale 1ns/1ps
module adc_sequencing_control_props (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [7:0] mode_wdata,
    input wire logic       mode_write,
    input wire logic [7:0] converter_mode_register,
    input wire logic [7:0] conversion_result_register,
    input wire logic       busy,
    input wire logic       conversion_done_request
);
    localparam int LO = adc_seq_pkg::CONV_CYCLES - 20;
    logic [9:0] cnt_q;
    logic       ran_q;
    logic       seen_q;
    // Cycles since the last mode write, saturating
    always_ff @(posedge clock) begin
        if (rst || mode_write) begin
            cnt_q <= 10'h000;
        end else if (cnt_q != 10'h3FF) begin
            cnt_q <= cnt_q + 10'h001;
        end
    end
    always_ff @(posedge clock) begin
        if (rst || mode_write) begin
            ran_q <= !rst && mode_wdata[7] && !mode_wdata[4];
            seen_q <= 1'b0;
        end else if (conversion_done_request) begin
            seen_q <= 1'b1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence sw_start;
        mode_write && mode_wdata[7] && !mode_wdata[4];
    endsequence
    AST_DONE_PULSE: assert property (conversion_done_request |=> !conversion_done_request)
        else $error("done request longer than one cycle");
    AST_RESET_IDLE: assert property ($fell(rst) |-> converter_mode_register == 8'h00 && !busy)
        else $error("not idle after reset");
    AST_MODE_WRITE: assert property (mode_write |=> converter_mode_register == $past(mode_wdata))
        else $error("mode write not taken");
    AST_STOP_IDLE: assert property (mode_write && !mode_wdata[7] |-> ##[1:2] !busy)
        else $error("busy after stop");
    AST_SW_START: assert property (sw_start |-> ##[1:2] busy)
        else $error("software start ignored");
    AST_RESULT_ON_DONE: assert property ($changed(conversion_result_register)
        |-> conversion_done_request || $past(conversion_done_request))
        else $error("result changed without done");
    AST_CONV_MIN: assert property (conversion_done_request |-> cnt_q >= LO)
        else $error("conversion too short");
    AST_CONV_MAX: assert property (ran_q && cnt_q == 10'h316 |-> seen_q)
        else $error("conversion too long");
endmodule // adc_sequencing_control_props

bind adc_sequencing_control adc_sequencing_control_props u_props (
    .clock(clock), .rst(rst), .mode_wdata(mode_wdata), .mode_write(mode_write),
    .converter_mode_register(converter_mode_register),
    .conversion_result_register(conversion_result_register),
    .busy(busy), .conversion_done_request(conversion_done_request));

// ### testbench/adc_sequencing_control_tb.sv
// Self-checking bench for the converter sequencing control
`timescale 1ns/1ps
module adc_sequencing_control_tb;
    typedef struct packed { logic [7:0] mode; logic [7:0] exp; } row_t;
    localparam logic [63:0] LEVELS = 64'hFE01AA557F80FF00;
    localparam int          CONV   = adc_seq_pkg::CONV_CYCLES;
    logic clock = 1'b0, rst = 1'b1, mode_write = 1'b0, trig = 1'b0;
    logic [7:0] mode_wdata = 8'h00, mode_q, result, trial;
    logic [2:0] chan;
    logic       compare_hi, busy, done, sampling;
    int         n_fail = 0, comparisons = 0, cycles = 0, n, hits;
    row_t rows [6] = '{'{8'h80, 8'h00}, '{8'h81, 8'hFF}, '{8'h82, 8'h80},
                       '{8'h83, 8'h7F}, '{8'h86, 8'h01}, '{8'h87, 8'hFE}};
    adc_sequencing_control dut (.clock(clock), .rst(rst), .mode_wdata(mode_wdata),
        .mode_write(mode_write), .external_trigger_input(trig), .compare_hi(compare_hi),
        .converter_mode_register(mode_q), .conversion_result_register(result),
        .analog_input_channels(chan), .dac_trial(trial), .sample_hold(sampling),
        .busy(busy), .conversion_done_request(done));
    analog_front_end #(.LEVELS(LEVELS)) afe (.channel(chan), .trial(trial),
        .compare_hi(compare_hi));
    always #5 clock = ~clock;
    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hang guard, well above the roughly 11k cycles the sequence needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("unexpected %0t: run did not finish", $time);
            end_of_test();
        end
    end
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input string what);
        check_val({7'h00, got}, 8'h01, what);
    endtask
    task automatic write_mode(input logic [7:0] v);
        mode_wdata <= v;
        mode_write <= 1'b1;
        @(posedge clock);
        mode_write <= 1'b0;
    endtask
    // Waits for a done pulse, then one edge more to step past it; the result lands on the same edge as the pulse
    task automatic wait_done(output int k);
        k = 0;
        while (done !== 1'b1 && k < 1000) begin
            @(posedge clock);
            k++;
        end
        check_flag(done, "done request seen");
        @(posedge clock);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        check_val(mode_q, 8'h00, "mode after reset");
        check_flag(busy === 1'b0 && done === 1'b0, "idle after reset");
        foreach (rows[i]) begin
            write_mode(rows[i].mode);
            wait_done(n);
            check_flag(n >= CONV - 20 && n <= CONV + 30, "conversion time");
            check_val(result, rows[i].exp, "select result");
            check_val(mode_q, rows[i].mode, "mode readback");
        end
        wait_done(n);
        check_val(result, 8'hFE, "select repeat");
        write_mode(8'h8A);
        for (int k = 0; k < 4; k++) begin
            wait_done(n);
            check_val(result, LEVELS[(k % 3) * 8 +: 8], "scan result");
        end
        write_mode(8'h83);
        repeat (300) @(posedge clock);
        write_mode(8'h84);
        repeat (2) @(posedge clock);
        check_flag(sampling === 1'b1, "restart returns to sampling");
        wait_done(n);
        check_flag(n >= CONV - 20, "restart from sampling");
        check_val(result, 8'h55, "restart result");
        write_mode(8'h91);
        repeat (20) @(posedge clock);
        check_flag(busy === 1'b0, "hardware start waits for edge");
        trig <= 1'b1;
        wait_done(n);
        check_val(result, 8'hFF, "hardware start result");
        trig <= 1'b0;
        write_mode(8'h00);
        hits = 0;
        repeat (800) begin
            @(posedge clock);
            hits += int'(done === 1'b1);
        end
        check_flag(hits == 0 && busy === 1'b0, "terminate stops conversion");
        end_of_test();
    end
endmodule // adc_sequencing_control_tb
